// File: lem_pkg.sv
package lem_pkg;
   // ------------------------------------------------------------
   // register indices (byte address is four times the index)
   // ------------------------------------------------------------
   localparam logic [11:0] IDX_SYNC_CTRL = 12'h047b;
   localparam logic [11:0] IDX_LIMIT = 12'h047c;
   localparam logic [11:0] IDX_LANE_ON = 12'h047d;
   localparam logic [11:0] IDX_RAMP = 12'h047e;
   localparam logic [11:0] IDX_IRQ_MASK = 12'h047f;
   localparam logic [11:0] IDX_FLAGS = 12'h0480;
   localparam int ADDR_W = 14;
   // ------------------------------------------------------------
   // field positions
   // ------------------------------------------------------------
   localparam int BIT_DISP = 7;
   localparam int BIT_NIT = 6;
   localparam int BIT_UCC = 5;
   localparam int BIT_CMM = 4;
   localparam int BIT_CMM_ON = 3;
   localparam int BIT_RAMP_ON = 0;
   localparam int BIT_RAMP_FAIL = 0;
   // ------------------------------------------------------------
   // reset values
   // ------------------------------------------------------------
   localparam logic [7:0] RST_SYNC_CTRL = 8'h08;
   localparam logic [7:0] RST_LIMIT = 8'hff;
   localparam logic [7:0] RST_LANE_ON = 8'h0f;
   localparam logic [7:0] RST_RAMP = 8'h00;
   localparam logic [7:0] RST_IRQ_MASK = 8'h00;
   localparam int RAMP_LEN = 3;
   localparam int CFG_BYTES = 14;
   localparam int CNT_W = 8;
   typedef enum logic [1:0] {
      LEM_IDLE = 2'b00,
      LEM_CHECK = 2'b01,
      LEM_DONE = 2'b10
   } lem_ramp_type;
endpackage : lem_pkg

// File: lem_lane_if.sv
`timescale 1ns/1ns
interface lem_lane_if #(
   parameter int LANES = 8
);
   logic [LANES-1:0] lane_on;
   logic [7:0] limit;
   logic clear;
   logic [LANES-1:0] disp_ev;
   logic [LANES-1:0] nit_ev;
   logic [LANES-1:0] ucc_ev;
   logic [LANES-1:0] disp_hit;
   logic [LANES-1:0] nit_hit;
   logic [LANES-1:0] ucc_hit;
   modport ctrl (output lane_on, limit, clear, disp_ev, nit_ev, ucc_ev,
                 input disp_hit, nit_hit, ucc_hit);
   modport cnt (input lane_on, limit, clear, disp_ev, nit_ev, ucc_ev,
                output disp_hit, nit_hit, ucc_hit);
endinterface : lem_lane_if

// File: lem_err_cnt.sv
`timescale 1ns/1ns
module lem_err_cnt #(
   parameter int LANES = 8
) (
   input wire logic pclk,
   input wire logic presetn,
   lem_lane_if.cnt lnk
);
   import lem_pkg::*;
   // ------------------------------------------------------------
   // one saturating counter per lane and per error type
   // ------------------------------------------------------------
   logic [CNT_W-1:0] disp_r [LANES];
   logic [CNT_W-1:0] nit_r [LANES];
   logic [CNT_W-1:0] ucc_r [LANES];

   initial begin
      if (LANES < 1 || LANES > 8) $error("lem_err_cnt: LANES must be 1..8");
   end

   function automatic logic [CNT_W-1:0] bump(input logic [CNT_W-1:0] c, input logic ev);
      // saturate so a long error burst cannot wrap below the limit
      bump = (ev && c != {CNT_W{1'b1}}) ? c + 1'b1 : c;
   endfunction : bump

   for (genvar i = 0; i < LANES; i++) begin : g_lane
      always_ff @(posedge pclk or negedge presetn) begin
         if (!presetn) begin
            disp_r[i] <= '0;
            nit_r[i] <= '0;
            ucc_r[i] <= '0;
         end else if (lnk.clear || !lnk.lane_on[i]) begin
            disp_r[i] <= '0;
            nit_r[i] <= '0;
            ucc_r[i] <= '0;
         end else begin
            disp_r[i] <= bump(disp_r[i], lnk.disp_ev[i]);
            nit_r[i] <= bump(nit_r[i], lnk.nit_ev[i]);
            ucc_r[i] <= bump(ucc_r[i], lnk.ucc_ev[i]);
         end
      end
      assign lnk.disp_hit[i] = lnk.lane_on[i] && disp_r[i] >= lnk.limit;
      assign lnk.nit_hit[i] = lnk.lane_on[i] && nit_r[i] >= lnk.limit;
      assign lnk.ucc_hit[i] = lnk.lane_on[i] && ucc_r[i] >= lnk.limit;
   end
endmodule : lem_err_cnt

// File: lem_top.sv
// Operation
// - disparity count at limit raises sync request
// - table-miss count at limit raises sync request
// - control-char count at limit raises sync request
// - mismatch rising edge latches status, irq low
// - mismatch status clears on write one
// - mismatch when lane-0 config differs from local
// - irq enable resets one; off disables status
// - per-lane counts compared with 8-bit limit
// - lane-enable bit x enables lane x
// - ramp check off accepts any alignment data
// - ramp check on requires 00-01-02, else fail
// - control-char mask pulls irq low at limit
// - read-only table-miss flag at limit
`timescale 1ns/1ns
module lem_top #(
   parameter int LANES = 8
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [lem_pkg::ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic [LANES-1:0] disp_err,
   input wire logic [LANES-1:0] nit_err,
   input wire logic [LANES-1:0] ucc_err,
   input wire logic [8*lem_pkg::CFG_BYTES-1:0] rx_lane0_cfg,
   input wire logic [8*lem_pkg::CFG_BYTES-1:0] tx_link_cfg,
   input wire logic cfg_valid,
   input wire logic ilas_start,
   input wire logic ilas_valid,
   input wire logic [7:0] ilas_data,
   output logic [7:0] lane_on_bits,
   output logic sync_request_out,
   output logic irq_n,
   output logic ramp_fail,
   output logic link_start_ok
);
   import lem_pkg::*;

   initial begin
      if (LANES < 1 || LANES > 8) $error("lem_top: LANES must be 1..8");
   end

   // ------------------------------------------------------------
   // apb decode
   // ------------------------------------------------------------
   logic [11:0] idx;
   logic setup;
   logic wr_en;
   logic mapped;
   logic [7:0] rd_mux;

   assign idx = paddr[ADDR_W-1:2];
   assign setup = psel && !penable;
   // only the low byte lane carries register bits
   assign wr_en = psel && penable && pwrite && pstrb[0];
   assign pready = 1'b1;

   always_comb begin
      mapped = 1'b1;
      case (idx)
         IDX_SYNC_CTRL, IDX_LIMIT, IDX_LANE_ON, IDX_RAMP, IDX_IRQ_MASK, IDX_FLAGS: begin
            mapped = 1'b1;
         end
         default: begin
            mapped = 1'b0;
         end
      endcase
      if (paddr[1:0] != 2'b00) begin
         mapped = 1'b0;
      end
   end

   // ------------------------------------------------------------
   // control registers
   // ------------------------------------------------------------
   logic disp_sel_r;
   logic nit_sel_r;
   logic ucc_sel_r;
   logic cmm_on_r;
   logic [7:0] limit_r;
   logic [7:0] lane_on_r;
   logic ramp_on_r;
   logic disp_mask_r;
   logic nit_mask_r;
   logic ucc_mask_r;
   logic clr_cnt;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         disp_sel_r <= RST_SYNC_CTRL[BIT_DISP];
         nit_sel_r <= RST_SYNC_CTRL[BIT_NIT];
         ucc_sel_r <= RST_SYNC_CTRL[BIT_UCC];
         cmm_on_r <= RST_SYNC_CTRL[BIT_CMM_ON];
      end else if (wr_en && mapped && idx == IDX_SYNC_CTRL) begin
         disp_sel_r <= pwdata[BIT_DISP];
         nit_sel_r <= pwdata[BIT_NIT];
         ucc_sel_r <= pwdata[BIT_UCC];
         cmm_on_r <= pwdata[BIT_CMM_ON];
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         limit_r <= RST_LIMIT;
      end else if (wr_en && idx == IDX_LIMIT) begin
         limit_r <= pwdata[7:0];
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         lane_on_r <= RST_LANE_ON;
      end else if (wr_en && idx == IDX_LANE_ON) begin
         // changing lanes mid-link is not guarded; software sets this first
         lane_on_r <= pwdata[7:0];
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ramp_on_r <= RST_RAMP[BIT_RAMP_ON];
      end else if (wr_en && idx == IDX_RAMP) begin
         ramp_on_r <= pwdata[BIT_RAMP_ON];
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         disp_mask_r <= RST_IRQ_MASK[BIT_DISP];
         nit_mask_r <= RST_IRQ_MASK[BIT_NIT];
         ucc_mask_r <= RST_IRQ_MASK[BIT_UCC];
      end else if (wr_en && idx == IDX_IRQ_MASK) begin
         disp_mask_r <= pwdata[BIT_DISP];
         nit_mask_r <= pwdata[BIT_NIT];
         ucc_mask_r <= pwdata[BIT_UCC];
      end
   end

   // any write to the flag register with pstrb[0] set restarts every error count
   assign clr_cnt = wr_en && idx == IDX_FLAGS;

   // ------------------------------------------------------------
   // error counters
   // ------------------------------------------------------------
   lem_lane_if #(.LANES(LANES)) lnk ();

   assign lnk.lane_on = lane_on_r[LANES-1:0];
   assign lnk.limit = limit_r;
   assign lnk.clear = clr_cnt;
   assign lnk.disp_ev = disp_err;
   assign lnk.nit_ev = nit_err;
   assign lnk.ucc_ev = ucc_err;

   lem_err_cnt #(.LANES(LANES)) u_cnt (
      .pclk(pclk),
      .presetn(presetn),
      .lnk(lnk)
   );

   logic disp_any;
   logic nit_any;
   logic ucc_any;

   assign disp_any = |lnk.disp_hit;
   assign nit_any = |lnk.nit_hit;
   assign ucc_any = |lnk.ucc_hit;

   // ------------------------------------------------------------
   // sync request
   // ------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sync_request_out <= 1'b0;
      end else begin
         sync_request_out <= (disp_sel_r && disp_any)
                          || (nit_sel_r && nit_any)
                          || (ucc_sel_r && ucc_any);
      end
   end

   // ------------------------------------------------------------
   // configuration mismatch
   // ------------------------------------------------------------
   logic mm;
   logic mm_d_r;
   logic cmm_r;
   logic cmm_clr;

   assign mm = cfg_valid && (rx_lane0_cfg != tx_link_cfg);
   assign cmm_clr = wr_en && idx == IDX_SYNC_CTRL && pwdata[BIT_CMM];

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mm_d_r <= 1'b0;
      end else begin
         mm_d_r <= mm;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cmm_r <= 1'b0;
      end else if (!cmm_on_r) begin
         cmm_r <= 1'b0;
      end else if (mm && !mm_d_r) begin
         // a new edge in the clearing cycle wins over the clear
         cmm_r <= 1'b1;
      end else if (cmm_clr) begin
         cmm_r <= 1'b0;
      end
   end

   // ------------------------------------------------------------
   // interrupt
   // ------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq_n <= 1'b1;
      end else begin
         irq_n <= !((cmm_on_r && cmm_r)
                 || (ucc_mask_r && ucc_any)
                 || (disp_mask_r && disp_any)
                 || (nit_mask_r && nit_any));
      end
   end

   // ------------------------------------------------------------
   // alignment ramp check
   // ------------------------------------------------------------
   lem_ramp_type st_r;
   logic [1:0] ramp_idx_r;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st_r <= LEM_IDLE;
         ramp_idx_r <= '0;
         ramp_fail <= 1'b0;
      end else if (ilas_start) begin
         st_r <= LEM_CHECK;
         ramp_idx_r <= '0;
         ramp_fail <= 1'b0;
      end else begin
         case (st_r)
            LEM_CHECK: begin
               if (ilas_valid) begin
                  // with the check off any data passes
                  if (ramp_on_r && ilas_data != {6'h00, ramp_idx_r}) begin
                     ramp_fail <= 1'b1;
                  end
                  if (ramp_idx_r == 2'(RAMP_LEN - 1)) begin
                     st_r <= LEM_DONE;
                  end
                  ramp_idx_r <= ramp_idx_r + 2'b01;
               end
            end
            LEM_DONE: begin
               st_r <= LEM_DONE;
            end
            default: begin
               st_r <= LEM_IDLE;
            end
         endcase
      end
   end

   assign link_start_ok = (st_r == LEM_DONE) && !ramp_fail;
   assign lane_on_bits = lane_on_r;

   // ------------------------------------------------------------
   // read data
   // ------------------------------------------------------------
   always_comb begin
      rd_mux = 8'h00;
      case (idx)
         IDX_SYNC_CTRL: begin
            rd_mux = {disp_sel_r, nit_sel_r, ucc_sel_r, cmm_r, cmm_on_r, 3'b000};
         end
         IDX_LIMIT: begin
            rd_mux = limit_r;
         end
         IDX_LANE_ON: begin
            rd_mux = lane_on_r;
         end
         IDX_RAMP: begin
            rd_mux = {7'h00, ramp_on_r};
         end
         IDX_IRQ_MASK: begin
            rd_mux = {disp_mask_r, nit_mask_r, ucc_mask_r, 5'h00};
         end
         IDX_FLAGS: begin
            rd_mux = {disp_any, nit_any, ucc_any, 4'h0, ramp_fail};
         end
         default: begin
            rd_mux = 8'h00;
         end
      endcase
   end

   // answer is captured in setup so prdata comes from a flop
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= 32'h0000_0000;
         pslverr <= 1'b0;
      end else if (setup) begin
         prdata <= (mapped && !pwrite) ? {24'h00_0000, rd_mux} : 32'h0000_0000;
         pslverr <= !mapped;
      end
   end
endmodule : lem_top

// File: lem_chk_properties.sv
`timescale 1ns/1ns
// ------------------------------------------------
// port checks of the link error monitor
// ------------------------------------------------
module lem_chk #(
   parameter int LANES = 8
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [lem_pkg::ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   input wire logic pready,
   input wire logic [8*lem_pkg::CFG_BYTES-1:0] rx_lane0_cfg,
   input wire logic [8*lem_pkg::CFG_BYTES-1:0] tx_link_cfg,
   input wire logic cfg_valid,
   input wire logic ilas_valid,
   input wire logic [7:0] lane_on_bits,
   input wire logic sync_request_out,
   input wire logic irq_n,
   input wire logic ramp_fail,
   input wire logic link_start_ok
);
   import lem_pkg::*;
   logic wr;
   logic mism;
   logic [7:0] sel_r;
   logic [7:0] lim_r;
   logic [7:0] mask_r;
   logic ramp_on_r;
   assign wr = psel & penable & pwrite & pstrb[0];
   assign mism = cfg_valid & (rx_lane0_cfg != tx_link_cfg);
   // shadow of the written controls; bit 4 of sel_r is never used
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sel_r <= RST_SYNC_CTRL;
         lim_r <= RST_LIMIT;
         mask_r <= RST_IRQ_MASK;
         ramp_on_r <= 1'b0;
      end else if (wr) begin
         if (paddr[13:2] == IDX_SYNC_CTRL) sel_r <= pwdata[7:0];
         if (paddr[13:2] == IDX_LIMIT) lim_r <= pwdata[7:0];
         if (paddr[13:2] == IDX_IRQ_MASK) mask_r <= pwdata[7:0];
         if (paddr[13:2] == IDX_RAMP) ramp_on_r <= pwdata[0];
      end
   end
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   a_reset_idle: assert property ($rose(presetn) |->
      lane_on_bits == 8'h0f && irq_n && !sync_request_out) else $error("reset state");
   a_lane_write: assert property (wr && paddr[13:2] == IDX_LANE_ON |=>
      lane_on_bits == $past(pwdata[7:0])) else $error("lane enable write");
   a_sync_select: assert property ($rose(sync_request_out) |->
      ($past(sel_r) & 8'he0) != 8'h00) else $error("sync without select");
   a_irq_source: assert property ($fell(irq_n) |->
      ($past(sel_r) & 8'h08) != 8'h00 || ($past(mask_r) & 8'he0) != 8'h00)
      else $error("irq cause");
   a_cmm_latch: assert property ($rose(mism) && sel_r[3] |-> ##2 !irq_n)
      else $error("mismatch irq");
   a_ramp_gate: assert property ($rose(ramp_fail) |-> $past(ramp_on_r))
      else $error("ramp fail while off");
   // the done state may only follow a strobed alignment byte
   a_start_ok: assert property ($rose(link_start_ok) |-> $past(ilas_valid))
      else $error("start without byte");
   a_limit_zero: assert property (lim_r == 8'h00 && sel_r[7] && lane_on_bits != 8'h00 |=>
      sync_request_out) else $error("zero limit sync");
   a_pready_tie: assert property (pready) else $error("wait state");
endmodule : lem_chk

bind lem_top lem_chk #(.LANES(LANES)) u_chk (.*);

// File: lem_tx_model.sv
`timescale 1ns/1ns
// ------------------------------------------------
// transmitter side of the link
// ------------------------------------------------
module lem_tx_model #(
   parameter int LANES = 8
) (
   input wire logic pclk,
   output logic [LANES-1:0] disp_err,
   output logic [LANES-1:0] nit_err,
   output logic [LANES-1:0] ucc_err,
   output logic [8*lem_pkg::CFG_BYTES-1:0] rx_lane0_cfg,
   output logic cfg_valid,
   output logic ilas_start,
   output logic ilas_valid,
   output logic [7:0] ilas_data
);
   import lem_pkg::*;
   initial begin
      disp_err = '0;
      nit_err = '0;
      ucc_err = '0;
      rx_lane0_cfg = '0;
      cfg_valid = 1'b0;
      ilas_start = 1'b0;
      ilas_valid = 1'b0;
      ilas_data = 8'hff;
   end
   // n back-to-back strobes; kind 0 disparity, 1 table miss, 2 control char
   task automatic errs(input int kind, input int lane, input int n);
      logic [LANES-1:0] hot;
      hot = '0;
      hot[lane] = 1'b1;
      repeat (n) begin
         @(posedge pclk);
         disp_err <= (kind == 0) ? hot : '0;
         nit_err <= (kind == 1) ? hot : '0;
         ucc_err <= (kind == 2) ? hot : '0;
      end
      @(posedge pclk);
      disp_err <= '0;
      nit_err <= '0;
      ucc_err <= '0;
   endtask : errs
   task automatic set_cfg(input logic [8*CFG_BYTES-1:0] v, input logic ok);
      @(posedge pclk);
      rx_lane0_cfg <= v;
      cfg_valid <= ok;
   endtask : set_cfg
   // inverse byte between strobes so stale data never passes for a ramp
   task automatic ilas(input logic [23:0] seq);
      @(posedge pclk);
      ilas_start <= 1'b1;
      for (int i = 0; i < 3; i++) begin
         @(posedge pclk);
         ilas_start <= 1'b0;
         ilas_valid <= 1'b1;
         ilas_data <= seq[23-8*i -: 8];
         @(posedge pclk);
         ilas_valid <= 1'b0;
         ilas_data <= ~seq[23-8*i -: 8];
      end
   endtask : ilas
endmodule : lem_tx_model

// File: tb_link_error_monitor.sv
`timescale 1ns/1ns
// ------------------------------------------------
// register-level test of the error monitor
// ------------------------------------------------
module tb_link_error_monitor;
   import lem_pkg::*;
   logic pclk, presetn, psel, penable, pwrite, err, pready, pslverr;
   logic [ADDR_W-1:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic [3:0] pstrb;
   logic [7:0] disp_err, nit_err, ucc_err, ilas_data, lane_on_bits;
   logic [8*CFG_BYTES-1:0] rx_lane0_cfg, tx_link_cfg;
   logic cfg_valid, ilas_start, ilas_valid, sync_request_out, irq_n, ramp_fail, link_start_ok;
   int bad_count = 0;
   int cmp_count = 0;
   int cycles = 0;
   lem_top #(.LANES(8)) DUT (.*);
   lem_tx_model #(.LANES(8)) u_tx (.*);
   task automatic end_sim();
      $display("mismatches %0d comparisons %0d", bad_count, cmp_count);
      if (bad_count == 0 && cmp_count > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask : end_sim
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      cmp_count++;
      if (got !== exp) begin
         bad_count++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      end
   endtask : chk
   task automatic apb(input logic [11:0] idx, input logic w, input logic [7:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= {idx, 2'b00};
      pwdata <= 32'(d);
      pstrb <= 4'hf;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   // outputs are registered one cycle behind their cause
   task automatic wt(input int n);
      repeat (n) @(posedge pclk);
      @(negedge pclk);
   endtask : wt
   initial begin
      pclk = 1'b0;
      forever #25 pclk = ~pclk;
   end
   always @(posedge pclk) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         bad_count++;
         end_sim();
      end
   end
   initial begin
      static logic [7:0] rst_v[4] = '{8'h08, 8'hff, 8'h0f, 8'h00};
      presetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = '0;
      pwdata = '0;
      pstrb = '0;
      tx_link_cfg = {14{8'h5a}};
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
      for (int i = 0; i < 4; i++) begin
         apb(IDX_SYNC_CTRL + 12'(i), 1'b0, 8'h00);
         chk("reset value", 32'(rst_v[i]), rd);
      end
      apb(12'h0481, 1'b0, 8'h00);
      chk("unmapped error", 32'h1, 32'(err));
      apb(IDX_LANE_ON, 1'b1, 8'h05);
      // the register updates on the access edge itself; look once it has settled
      wt(0);
      chk("lane enables", 32'h5, 32'(lane_on_bits));
      for (int t = 0; t < 3; t++) begin
         apb(IDX_FLAGS, 1'b1, 8'h00);
         apb(IDX_SYNC_CTRL, 1'b1, 8'h08 | (8'h80 >> t));
         apb(IDX_LIMIT, 1'b1, 8'h03);
         u_tx.errs(t, 0, 2);
         u_tx.errs(t, 1, 5);
         u_tx.errs(t, 2, 1);
         wt(1);
         chk("sync below limit", 32'h0, 32'(sync_request_out));
         u_tx.errs(t, 0, 1);
         wt(1);
         chk("sync at limit", 32'h1, 32'(sync_request_out));
         apb(IDX_FLAGS, 1'b0, 8'h00);
         chk("hit flags", 32'(8'h80 >> t), rd);
      end
      apb(IDX_SYNC_CTRL, 1'b1, 8'h88);
      apb(IDX_LIMIT, 1'b1, 8'h00);
      wt(1);
      chk("sync zero limit", 32'h1, 32'(sync_request_out));
      apb(IDX_SYNC_CTRL, 1'b1, 8'h08);
      apb(IDX_LIMIT, 1'b1, 8'h01);
      apb(IDX_IRQ_MASK, 1'b1, 8'h20);
      apb(IDX_FLAGS, 1'b1, 8'h00);
      u_tx.errs(2, 2, 1);
      wt(1);
      chk("irq from mask", 32'h0, 32'(irq_n));
      apb(IDX_FLAGS, 1'b1, 8'h00);
      wt(1);
      chk("irq after count clear", 32'h1, 32'(irq_n));
      // the other two mask bits, one error type each
      apb(IDX_IRQ_MASK, 1'b1, 8'hc0);
      u_tx.errs(1, 0, 1);
      wt(1);
      chk("irq from table miss", 32'h0, 32'(irq_n));
      apb(IDX_FLAGS, 1'b1, 8'h00);
      u_tx.errs(0, 2, 1);
      wt(1);
      chk("irq from disparity", 32'h0, 32'(irq_n));
      apb(IDX_FLAGS, 1'b1, 8'h00);
      apb(IDX_IRQ_MASK, 1'b1, 8'h00);
      u_tx.set_cfg(tx_link_cfg, 1'b1);
      wt(2);
      chk("irq config equal", 32'h1, 32'(irq_n));
      u_tx.set_cfg(~tx_link_cfg, 1'b1);
      wt(2);
      chk("irq on mismatch", 32'h0, 32'(irq_n));
      u_tx.set_cfg(tx_link_cfg, 1'b1);
      apb(IDX_SYNC_CTRL, 1'b1, 8'h08);
      apb(IDX_SYNC_CTRL, 1'b0, 8'h00);
      chk("status held", 32'h18, rd);
      apb(IDX_SYNC_CTRL, 1'b1, 8'h18);
      wt(1);
      chk("irq after status clear", 32'h1, 32'(irq_n));
      apb(IDX_SYNC_CTRL, 1'b1, 8'h00);
      u_tx.set_cfg(~tx_link_cfg, 1'b1);
      wt(2);
      apb(IDX_SYNC_CTRL, 1'b0, 8'h00);
      chk("status disabled", 32'h0, rd);
      chk("irq disabled", 32'h1, 32'(irq_n));
      u_tx.ilas(24'h05_0709);
      wt(1);
      chk("start unchecked", 32'h1, 32'(link_start_ok & ~ramp_fail));
      apb(IDX_RAMP, 1'b1, 8'h01);
      u_tx.ilas(24'h00_0102);
      wt(1);
      chk("good ramp", 32'h1, 32'(link_start_ok & ~ramp_fail));
      u_tx.ilas(24'h00_0202);
      wt(1);
      chk("bad ramp", 32'h1, 32'(~link_start_ok & ramp_fail));
      apb(IDX_FLAGS, 1'b0, 8'h00);
      chk("fail flag", 32'h1, rd);
      end_sim();
   end
endmodule : tb_link_error_monitor
